/* logic/ptr_pkg.sv */
// Package: offsets, field positions and reset values of the power/timing/audio/status registers
package ptr_pkg;
	localparam logic [7:0] OFS_PWR   = 8'h26;
	localparam logic [7:0] OFS_CTRL  = 8'h27;
	localparam logic [7:0] OFS_VHDLY = 8'h28;
	localparam logic [7:0] OFS_HDLYL = 8'h29;
	localparam logic [7:0] OFS_LWH   = 8'h2a;
	localparam logic [7:0] OFS_LWL   = 8'h2b;
	localparam logic [7:0] OFS_SHH   = 8'h2c;
	localparam logic [7:0] OFS_SHL   = 8'h2d;
	localparam logic [7:0] OFS_AUD   = 8'h2e;
	localparam logic [7:0] OFS_LSTAT = 8'h2f;
	localparam logic [7:0] OFS_ESTAT = 8'h30;
	// Field positions
	localparam int B_PD_POL   = 3;
	localparam int B_PD_FN_HI = 2;
	localparam int B_PD_FN_LO = 1;
	localparam int B_PD       = 0;
	localparam int B_AUTO_PD  = 7;
	localparam int B_KEY_ADDR = 6;
	localparam int B_MCLK_EXT = 5;
	localparam int B_MARKER   = 4;
	localparam int B_DE_GEN   = 3;
	localparam int B_CTRL_EN  = 7;
	// Reset values
	localparam logic       RST_PD_POL   = 1'b1;
	localparam logic [1:0] RST_PD_FN    = 2'h0;
	localparam logic       RST_AUTO_PD  = 1'b1;
	localparam logic [2:0] RST_FOFS     = 3'h0;
	localparam logic [5:0] RST_VDELAY   = 6'h18;
	localparam logic [9:0] RST_HDELAY   = 10'h104;
	localparam logic [11:0] RST_LWIDTH  = 12'h500;
	localparam logic [11:0] RST_SHEIGHT = 12'h2d0;
	localparam logic [4:0] RST_AWIDTH   = 5'h18;
	// Pin function codes
	typedef enum logic [1:0] {
		PF_OFF_SOG  = 2'h0,
		PF_OFF_ALL  = 2'h1,
		PF_ON_SOG   = 2'h2,
		PF_ON_ALL   = 2'h3
	} ptr_pin_fn_t;
	// Serial audio formats
	typedef enum logic [1:0] {
		AF_STD   = 2'h0,
		AF_RIGHT = 2'h1,
		AF_LEFT  = 2'h2,
		AF_RAW   = 2'h3
	} ptr_aud_fmt_t;
	localparam int STAT_W = 14;
endpackage : ptr_pkg

/* logic/ptr_regs.sv */
// Power, timing, serial audio and link status register bank with DE generator
`timescale 1ns/1ps
module ptr_regs #(
	parameter int CNT_W = 12
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic [7:0]       o_reg_rdata,
	input  wire logic        i_power_down_pin,
	input  wire logic        i_sync_present,
	output logic             o_low_power,
	output logic             o_video_oe,
	output logic             o_sync_on_green_oe,
	output logic             o_key_addr_lsb,
	output logic             o_mclk_ext_sel,
	output logic [2:0]       o_field_offset,
	input  wire logic        i_hsync,
	input  wire logic        i_vsync,
	input  wire logic        i_link_de,
	output logic             o_display_enable,
	output logic             o_sav,
	output logic             o_eav,
	input  wire logic [3:0]  i_audio_data,
	input  wire logic [3:0]  i_link_ctrl,
	output logic [3:0]       o_audio_data,
	output ptr_pkg::ptr_aud_fmt_t o_audio_format,
	output logic [4:0]       o_audio_width,
	input  wire logic        i_de_present,
	input  wire logic        i_clk_present,
	input  wire logic        i_av_mute,
	input  wire logic        i_keys_read,
	input  wire logic [2:0]  i_link_quality,
	input  wire logic        i_decrypting,
	input  wire logic        i_hs_pol,
	input  wire logic        i_vs_pol,
	input  wire logic [3:0]  i_pixel_repeat
);
	import ptr_pkg::*;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic        pd_pol_q;
	ptr_pin_fn_t pd_fn_q;
	logic        pd_q;
	logic        auto_pd_q;
	logic        key_addr_q;
	logic        mclk_ext_q;
	logic        marker_q;
	logic        de_gen_q;
	logic [2:0]  fofs_q;
	logic [5:0]  vdelay_q;
	logic [9:0]  hdelay_q;
	logic [11:0] lwidth_q;
	logic [11:0] sheight_q;
	logic        ctrl_en_q;
	ptr_aud_fmt_t afmt_q;
	logic [4:0]  awidth_q;

	wire wr_pwr   = i_reg_wr && (i_reg_addr == OFS_PWR);
	wire wr_ctrl  = i_reg_wr && (i_reg_addr == OFS_CTRL);
	wire wr_vhdly = i_reg_wr && (i_reg_addr == OFS_VHDLY);
	wire wr_hdlyl = i_reg_wr && (i_reg_addr == OFS_HDLYL);
	wire wr_lwh   = i_reg_wr && (i_reg_addr == OFS_LWH);
	wire wr_lwl   = i_reg_wr && (i_reg_addr == OFS_LWL);
	wire wr_shh   = i_reg_wr && (i_reg_addr == OFS_SHH);
	wire wr_shl   = i_reg_wr && (i_reg_addr == OFS_SHL);
	wire wr_aud   = i_reg_wr && (i_reg_addr == OFS_AUD);

	// Writes never look at the power state, so software can always wake the part
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pd_pol_q <= RST_PD_POL;
			pd_fn_q  <= ptr_pin_fn_t'(RST_PD_FN);
			pd_q     <= 1'b0;
		end else if (wr_pwr) begin
			pd_pol_q <= i_reg_wdata[B_PD_POL];
			pd_fn_q  <= ptr_pin_fn_t'(i_reg_wdata[B_PD_FN_HI:B_PD_FN_LO]);
			pd_q     <= i_reg_wdata[B_PD];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			auto_pd_q  <= RST_AUTO_PD;
			key_addr_q <= 1'b0;
			mclk_ext_q <= 1'b0;
			marker_q   <= 1'b0;
			de_gen_q   <= 1'b0;
			fofs_q     <= RST_FOFS;
		end else if (wr_ctrl) begin
			auto_pd_q  <= i_reg_wdata[B_AUTO_PD];
			key_addr_q <= i_reg_wdata[B_KEY_ADDR];
			mclk_ext_q <= i_reg_wdata[B_MCLK_EXT];
			marker_q   <= i_reg_wdata[B_MARKER];
			de_gen_q   <= i_reg_wdata[B_DE_GEN];
			fofs_q     <= i_reg_wdata[2:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			vdelay_q  <= RST_VDELAY;
			hdelay_q  <= RST_HDELAY;
			lwidth_q  <= RST_LWIDTH;
			sheight_q <= RST_SHEIGHT;
		end else begin
			if (wr_vhdly) begin
				vdelay_q       <= i_reg_wdata[7:2];
				hdelay_q[9:8]  <= i_reg_wdata[1:0];
			end
			if (wr_hdlyl)
				hdelay_q[7:0]  <= i_reg_wdata;
			if (wr_lwh)
				lwidth_q[11:8] <= i_reg_wdata[3:0];
			if (wr_lwl)
				lwidth_q[7:0]  <= i_reg_wdata;
			if (wr_shh)
				sheight_q[11:8] <= i_reg_wdata[3:0];
			if (wr_shl)
				sheight_q[7:0] <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_en_q <= 1'b0;
			afmt_q    <= AF_STD;
			awidth_q  <= RST_AWIDTH;
		end else if (wr_aud) begin
			ctrl_en_q <= i_reg_wdata[B_CTRL_EN];
			afmt_q    <= ptr_aud_fmt_t'(i_reg_wdata[6:5]);
			awidth_q  <= i_reg_wdata[4:0];
		end
	end

	// ----------------------------------------
	// Pin and status synchronisers
	// ----------------------------------------
	logic [STAT_W+1:0] meta_q;
	logic [STAT_W+1:0] sync_q;
	wire  [STAT_W+1:0] raw_in = {i_power_down_pin, i_sync_present, i_de_present,
		i_clk_present, i_av_mute, i_keys_read, i_link_quality,
		i_decrypting, i_hs_pol, i_vs_pol, i_pixel_repeat};

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	wire       pin_s     = sync_q[STAT_W+1];
	wire       sync_s    = sync_q[STAT_W];
	wire [7:0] lstat     = {1'b0, sync_q[13:7]};
	wire [7:0] estat     = {1'b0, sync_q[6:0]};

	// ----------------------------------------
	// Power-down control
	// ----------------------------------------
	wire pin_active = (pin_s == pd_pol_q);
	wire pin_off    = pin_active && (pd_fn_q == PF_OFF_SOG || pd_fn_q == PF_OFF_ALL);
	wire pin_sog_z  = pin_active && (pd_fn_q == PF_OFF_ALL || pd_fn_q == PF_ON_ALL);
	wire auto_off   = auto_pd_q && !sync_s;

	// Only the datapath sleeps; this bank and sync detect stay alive
	assign o_low_power        = pd_q || pin_off || auto_off;
	assign o_video_oe         = !(pd_q || pin_active);
	assign o_sync_on_green_oe = !pin_sog_z;
	assign o_key_addr_lsb     = key_addr_q;
	// Lock of an external clock is the far side's job; no check here
	assign o_mclk_ext_sel     = mclk_ext_q;
	assign o_field_offset     = fofs_q;
	assign o_audio_format     = afmt_q;
	assign o_audio_width      = awidth_q;

	// ----------------------------------------
	// Display enable generator
	// ----------------------------------------
	logic             hs_d_q;
	logic             vs_d_q;
	logic             odd_q;
	logic [CNT_W-1:0] pix_q;
	logic [CNT_W-1:0] line_q;
	logic             gen_de_q;

	wire hs_edge = i_hsync && !hs_d_q;
	wire vs_edge = i_vsync && !vs_d_q;

	// Field 1 starts its active area later by the programmed count
	wire [CNT_W-1:0] v_start = CNT_W'(vdelay_q) + (odd_q ? CNT_W'(fofs_q) : '0);
	wire [CNT_W-1:0] v_stop  = v_start + CNT_W'(sheight_q);
	wire [CNT_W-1:0] h_start = CNT_W'(hdelay_q);
	wire [CNT_W-1:0] h_stop  = h_start + CNT_W'(lwidth_q);
	wire gen_de_d = (line_q >= v_start) && (line_q < v_stop)
		&& (pix_q >= h_start) && (pix_q < h_stop);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			hs_d_q   <= 1'b0;
			vs_d_q   <= 1'b0;
			odd_q    <= 1'b0;
			pix_q    <= '0;
			line_q   <= '0;
			gen_de_q <= 1'b0;
		end else begin
			hs_d_q   <= i_hsync;
			vs_d_q   <= i_vsync;
			gen_de_q <= gen_de_d;
			if (vs_edge) begin
				odd_q  <= !odd_q;
				line_q <= '0;
			end else if (hs_edge) begin
				line_q <= line_q + 1'b1;
			end
			pix_q <= hs_edge ? '0 : pix_q + 1'b1;
		end
	end

	// ----------------------------------------
	// Enable select and marker insertion
	// ----------------------------------------
	logic de_q;
	logic sav_q;
	logic eav_q;
	// Switching the source mid-line can itself raise a marker
	wire  de_d = de_gen_q ? gen_de_q : i_link_de;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			de_q      <= 1'b0;
			sav_q     <= 1'b0;
			eav_q     <= 1'b0;
		end else begin
			de_q      <= de_d;
			sav_q     <= marker_q && de_d && !de_q;
			eav_q     <= marker_q && !de_d && de_q;
		end
	end

	assign o_display_enable = de_q;
	assign o_sav            = sav_q;
	assign o_eav            = eav_q;

	// ----------------------------------------
	// Serial audio data routing
	// ----------------------------------------
	logic [3:0] aud_q;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			aud_q <= '0;
		else
			aud_q <= ctrl_en_q ? i_link_ctrl : i_audio_data;
	end
	assign o_audio_data = aud_q;

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] rdata_q;
	always_comb begin
		unique case (i_reg_addr)
			OFS_PWR:   rd_mux = {4'h0, pd_pol_q, pd_fn_q, pd_q};
			OFS_CTRL:  rd_mux = {auto_pd_q, key_addr_q, mclk_ext_q, marker_q,
				de_gen_q, fofs_q};
			OFS_VHDLY: rd_mux = {vdelay_q, hdelay_q[9:8]};
			OFS_HDLYL: rd_mux = hdelay_q[7:0];
			OFS_LWH:   rd_mux = {4'h0, lwidth_q[11:8]};
			OFS_LWL:   rd_mux = lwidth_q[7:0];
			OFS_SHH:   rd_mux = {4'h0, sheight_q[11:8]};
			OFS_SHL:   rd_mux = sheight_q[7:0];
			OFS_AUD:   rd_mux = {ctrl_en_q, afmt_q, awidth_q};
			OFS_LSTAT: rd_mux = lstat;
			OFS_ESTAT: rd_mux = estat;
			default:   rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			rdata_q <= 8'h00;
		else if (i_reg_rd)
			rdata_q <= rd_mux;
	end
	assign o_reg_rdata = rdata_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_de_rise;
		marker_q && de_d && !de_q;
	endsequence
	sequence s_sav_out;
		o_sav && o_display_enable;
	endsequence
	sequence s_de_fall;
		marker_q && !de_d && de_q;
	endsequence
	sequence s_eav_out;
		o_eav && !o_display_enable;
	endsequence

	a_pin_polarity: assert property (!pd_q |-> o_video_oe == (pin_s != pd_pol_q))
		else $error("pin polarity does not gate outputs");
	a_pin_sog_float: assert property (pin_active && pd_fn_q == PF_OFF_ALL
		|-> !o_sync_on_green_oe && o_low_power)
		else $error("pin function 01 keeps sync-on-green or power");
	a_pin_stay_on: assert property (pin_active && pd_fn_q == PF_ON_SOG && !pd_q
		&& !auto_off |-> !o_low_power && o_sync_on_green_oe && !o_video_oe)
		else $error("pin function 10 misbehaves");
	a_pd_tristate: assert property ($rose(pd_q) && !pin_active
		|-> !o_video_oe && o_sync_on_green_oe && o_low_power)
		else $error("power-down bit does not float outputs");
	a_reg_live: assert property (pd_q && wr_shl |=> sheight_q[7:0] == $past(i_reg_wdata))
		else $error("register write lost in power-down");
	a_auto_pd: assert property (auto_pd_q && !sync_s |-> o_low_power)
		else $error("auto power-down did not act");
	a_clk_select: assert property (wr_ctrl |=> o_mclk_ext_sel == $past(i_reg_wdata[5])
		&& o_key_addr_lsb == $past(i_reg_wdata[6]))
		else $error("clock source or key address not taken");
	a_marker_sav: assert property (s_de_rise |=> s_sav_out)
		else $error("start marker missing");
	a_de_select: assert property (de_gen_q && $stable(de_gen_q)
		|=> o_display_enable == $past(gen_de_q))
		else $error("generated enable not used");
	a_ctrl_route: assert property (ctrl_en_q |=> o_audio_data == $past(i_link_ctrl))
		else $error("control bits not on audio pins");
	a_status_read: assert property (i_reg_rd && i_reg_addr == OFS_LSTAT
		|=> o_reg_rdata == {1'b0, $past(sync_q[13:7])})
		else $error("link status read wrong");
	a_repeat_read: assert property (i_reg_rd && i_reg_addr == OFS_ESTAT
		|=> o_reg_rdata[3:0] == $past(sync_q[3:0]) && !o_reg_rdata[7])
		else $error("repetition status read wrong");
	a_marker_eav: assert property (s_de_fall |=> s_eav_out)
		else $error("end marker missing");
	a_marker_off: assert property (!marker_q |=> !o_sav && !o_eav)
		else $error("marker sent while insertion is off");
	a_de_received: assert property (!de_gen_q
		|=> o_display_enable == $past(i_link_de))
		else $error("received enable not passed through");
	a_vdelay_write: assert property (wr_vhdly
		|=> vdelay_q == $past(i_reg_wdata[7:2])
		&& hdelay_q[9:8] == $past(i_reg_wdata[1:0]))
		else $error("vertical or horizontal delay write lost");
	a_aud_format: assert property (wr_aud
		|=> o_audio_format == $past(i_reg_wdata[6:5])
		&& o_audio_width == $past(i_reg_wdata[4:0]))
		else $error("audio format or width not taken");
endmodule : ptr_regs

/* tb/ptr_host.sv */
// Host controller model driving the internal register byte port
`timescale 1ns/1ps
module ptr_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_reg_rdata,
	output logic      [7:0] o_reg_addr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_wr,
	output logic            o_reg_rd
);
	initial begin
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
	end
	// Released address and data are inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_reg_addr <= a;
		o_reg_wdata <= d;
		o_reg_wr <= 1'b1;
		@(posedge i_clk);
		o_reg_wr <= 1'b0;
		o_reg_addr <= ~a;
		o_reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_reg_addr <= a;
		o_reg_rd <= 1'b1;
		@(posedge i_clk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		@(posedge i_clk);
		#1 d = i_reg_rdata;
	endtask : rd
endmodule : ptr_host

/* tb/ptr_regs_test.sv */
// Self-checking bench for the power, timing, audio and status register bank
`timescale 1ns/1ps
module ptr_regs_test;
	import ptr_pkg::*;
	logic         i_clk, i_sys_rst, reg_wr, reg_rd, pin, sync, hs, vs, link_en, mon;
	logic         lp, voe, soe, key, mext, disp_en, sav, eav;
	logic [7:0]   addr, wdata, rdata, d;
	logic [2:0]   fofs;
	logic [3:0]   aud, ctl, aout;
	logic [4:0]   awid;
	logic [13:0]  st;
	ptr_aud_fmt_t fmt;
	int           err_count, n_compared, n_en, n_sav, n_eav;
	// Rows: address, reset value, write value, value read back after the write
	localparam logic [31:0] ROWS [12] = '{32'h2608ff0f, 32'h27807f7f, 32'h2861a5a5,
		32'h29045a5a, 32'h2a05ff0f, 32'h2b003c3c, 32'h2c02fa0a, 32'h2dd0c3c3, 32'h2e18e7e7,
		32'h2f00ff00, 32'h3000ff00, 32'h4000ff00};
	localparam logic [15:0] TW [7] = '{16'h2804, 16'h2902, 16'h2a00, 16'h2b03, 16'h2c00,
		16'h2d02, 16'h2718};
	localparam logic [13:0] SP [2] = '{14'h2ad9, 14'h1526};

	// No external master clock source at these ports, so its lock stays untested
	ptr_host ptr_host_inst (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
		.o_reg_wdata(wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));
	ptr_regs #(.CNT_W(12)) ptr_regs_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.o_reg_rdata(rdata), .i_power_down_pin(pin), .i_sync_present(sync), .o_low_power(lp),
		.o_video_oe(voe), .o_sync_on_green_oe(soe), .o_key_addr_lsb(key), .o_mclk_ext_sel(mext),
		.o_field_offset(fofs), .i_hsync(hs), .i_vsync(vs), .i_link_de(link_en),
		.o_display_enable(disp_en), .o_sav(sav), .o_eav(eav), .i_audio_data(aud),
		.i_link_ctrl(ctl), .o_audio_data(aout), .o_audio_format(fmt), .o_audio_width(awid),
		.i_de_present(st[13]), .i_clk_present(st[12]), .i_av_mute(st[11]),
		.i_keys_read(st[10]), .i_link_quality(st[9:7]), .i_decrypting(st[6]),
		.i_hs_pol(st[5]), .i_vs_pol(st[4]), .i_pixel_repeat(st[3:0]));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (mon && disp_en === 1'b1) n_en++;
		if (mon && sav === 1'b1) n_sav++;
		if (mon && eav === 1'b1) n_eav++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		ptr_host_inst.rd(a, d);
		chk(d, exp);
	endtask : rchk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic chk_reset();
		for (int i = 0; i < 12; i++) begin
			rchk(ROWS[i][31:24], ROWS[i][23:16]);
		end
		chk({key, mext, fofs, fmt, awid}, 12'h018);
		chk({voe, soe, lp, disp_en}, 4'hc);
	endtask : chk_reset
	task automatic frame();
		n_en = 0;
		n_sav = 0;
		n_eav = 0;
		// Let a marker from switching the enable source pass first
		repeat (3) @(posedge i_clk);
		@(posedge i_clk) mon <= 1'b1;
		for (int l = 0; l < 8; l++) begin
			@(posedge i_clk) hs <= 1'b1;
			vs <= (l == 0);
			@(posedge i_clk) hs <= 1'b0;
			vs <= 1'b0;
			repeat (8) @(posedge i_clk);
		end
		repeat (3) @(posedge i_clk);
		mon <= 1'b0;
		#1;
	endtask : frame
	task automatic results();
		if (err_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// Run takes under 600 cycles; this bound of 20000 cycles is far beyond it
	initial begin
		#500000;
		err_count++;
		results();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		i_sys_rst = 1'b1;
		{pin, hs, vs, link_en, mon} = 5'h00;
		sync = 1'b1;
		aud = 4'ha;
		ctl = 4'h5;
		st = 14'h0000;
		err_count = 0;
		n_compared = 0;
		repeat (16) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		cyc(1);
		chk_reset();
		// Row auto_power_audio_clock_timing_ctrl sets the key bus address bit as a second receiver of a pair would
		for (int i = 0; i < 12; i++) ptr_host_inst.wr(ROWS[i][31:24], ROWS[i][15:8]);
		for (int i = 0; i < 12; i++) begin
			rchk(ROWS[i][31:24], ROWS[i][7:0]);
		end
		chk({key, mext, fofs, fmt, awid}, 12'hfe7);
		@(posedge i_clk) i_sys_rst <= 1'b1;
		cyc(3);
		@(posedge i_clk) i_sys_rst <= 1'b0;
		cyc(1);
		chk_reset();
		ptr_host_inst.wr(OFS_CTRL, 8'h00);
		for (int f = 0; f < 4; f++) begin
			ptr_host_inst.wr(OFS_PWR, {5'h01, f[1:0], 1'b0});
			@(posedge i_clk) pin <= 1'b1;
			cyc(3);
			chk({voe, soe, lp}, {1'b0, ~f[0], ~f[1]});
			@(posedge i_clk) pin <= 1'b0;
			cyc(3);
			chk({voe, soe, lp}, 3'b110);
		end
		ptr_host_inst.wr(OFS_PWR, 8'h00);
		cyc(3);
		chk({voe, soe, lp}, 3'b011);
		@(posedge i_clk) pin <= 1'b1;
		cyc(3);
		chk({voe, soe, lp}, 3'b110);
		@(posedge i_clk) pin <= 1'b0;
		ptr_host_inst.wr(OFS_PWR, 8'h09);
		cyc(3);
		chk({voe, soe, lp}, 3'b011);
		rchk(OFS_PWR, 8'h09);
		ptr_host_inst.wr(OFS_SHL, 8'h5a);
		rchk(OFS_SHL, 8'h5a);
		ptr_host_inst.wr(OFS_PWR, 8'h08);
		ptr_host_inst.wr(OFS_CTRL, 8'h80);
		@(posedge i_clk) sync <= 1'b0;
		cyc(3);
		chk(lp, 1'b1);
		ptr_host_inst.wr(OFS_CTRL, 8'h00);
		cyc(1);
		chk(lp, 1'b0);
		@(posedge i_clk) sync <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk) st <= SP[k];
			cyc(4);
			rchk(OFS_LSTAT, {1'b0, SP[k][13:7]});
			rchk(OFS_ESTAT, {1'b0, SP[k][6:0]});
		end
		ptr_host_inst.wr(OFS_AUD, 8'h80);
		cyc(2);
		chk(aout, 4'h5);
		@(posedge i_clk) ctl <= 4'h3;
		cyc(2);
		chk(aout, 4'h3);
		ptr_host_inst.wr(OFS_AUD, 8'h10);
		cyc(2);
		chk(aout, 4'ha);
		for (int f = 0; f < 4; f++) begin
			ptr_host_inst.wr(OFS_AUD, {1'b0, f[1:0], 3'h2, f[1:0]});
			cyc(1);
			chk({fmt, awid}, {f[1:0], 3'h2, f[1:0]});
		end
		@(posedge i_clk) link_en <= 1'b1;
		cyc(3);
		chk(disp_en, 1'b1);
		// Received enable stays high to show the generator overrides it
		for (int i = 0; i < 7; i++) ptr_host_inst.wr(TW[i][15:8], TW[i][7:0]);
		frame();
		chk({n_en[7:0], n_sav[3:0], n_eav[3:0]}, 16'h0622);
		// Offset 7 pushes field 1 past the last line of the short frame
		ptr_host_inst.wr(OFS_CTRL, 8'h0f);
		frame();
		chk({n_en[7:0], n_sav[3:0], n_eav[3:0]}, 16'h0600);
		frame();
		chk({n_en[7:0], n_sav[3:0], n_eav[3:0]}, 16'h0000);
		ptr_host_inst.wr(OFS_CTRL, 8'h00);
		cyc(3);
		chk(disp_en, 1'b1);
		results();
	end
endmodule : ptr_regs_test
